//--- design/recorder_mcu_control_port.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module recorder_mcu_control_port (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Chip pins
    input wire logic i_chip_reset,
    input wire logic i_sleep_n,
    input wire logic i_host_mode_select,
    input wire logic i_reg_count_strap_lo,
    input wire logic i_reg_count_strap_hi,
    input wire logic i_voice_detect,
    // Host nibble bus
    input wire recorder_port_pkg::host_strobes_type i_host_strobes,
    input wire logic [3:0] i_host_nibble_bus,
    output logic [3:0] o_host_nibble_bus,
    output logic o_host_nibble_bus_oe,
    // Status pins
    output logic o_busy,
    output logic o_rec_play_active,
    output logic o_voice_wait_or_pause,
    // Memory selects, active low
    output logic o_mem_select_1_n,
    output logic o_mem_select_2_n,
    output logic o_mem_select_3_n,
    output logic o_mem_select_4_n,
    // Register port
    input wire recorder_port_pkg::reg_req_type i_reg,
    output logic [recorder_port_pkg::DATA_W-1:0] o_rdata,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        recorder_port_pkg::ctrl_state_type st;
        logic rec_cut;
        logic wake_idle;
        logic paused_rec;
        logic wr_prev;
        logic [3:0] host_cmd;
        logic [3:0] host_dout;
        logic read_status;
        logic [1:0] mem_target;
        logic [1:0] reg_count_m1;
        logic [recorder_port_pkg::EV_W-1:0] irq_status;
        logic [recorder_port_pkg::EV_W-1:0] irq_mask;
        logic [recorder_port_pkg::DATA_W-1:0] rdata;
        logic irq;
        logic busy;
        logic rec_play_active;
        logic voice_wait_or_pause;
        logic [3:0] mem_sel_n;
        logic [3:0] nib_out;
        logic nib_oe;
    } core_type;

    localparam core_type CORE_INIT = '{
        st: recorder_port_pkg::ST_DOWN,
        wr_prev: 1'b1,
        mem_sel_n: 4'hf,
        default: '0
    };

    core_type s;
    core_type next_s;
    recorder_port_pkg::host_strobes_type pins_s;
    logic cmd_running;
    logic cmd_done;
    logic post_done;
    logic cmd_start;
    logic post_start;
    logic enable;
    logic wr_fall;
    logic rec_live;
    logic [1:0] mem_idx;
    logic [recorder_port_pkg::EV_W-1:0] ev;
    logic [recorder_port_pkg::EV_W-1:0] w1c;

    // Idle level of strobes: disabled, not strobing
    strobe_sync #(
        .WIDTH(4),
        .IDLE(4'hb)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_host_strobes),
        .o_sync(pins_s)
    );

    cycle_timer #(
        .WIDTH(recorder_port_pkg::TIMER_W)
    ) u_cmd_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_clear(i_chip_reset),
        .i_start(cmd_start),
        .i_load(recorder_port_pkg::CMD_BUSY_LOAD),
        .o_running(cmd_running),
        .o_done(cmd_done)
    );

    cycle_timer #(
        .WIDTH(recorder_port_pkg::TIMER_W)
    ) u_post_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_clear(i_chip_reset),
        .i_start(post_start),
        .i_load(recorder_port_pkg::POST_PROC_LOAD),
        .o_running(),
        .o_done(post_done)
    );

    always_comb begin
        next_s = s;
        ev = '0;
        w1c = '0;
        cmd_start = 1'b0;
        post_start = 1'b0;
        mem_idx = '0;
        // Host port only alive in interface mode
        enable = i_host_mode_select && (!pins_s.ce_n || pins_s.ce);
        // Edge on the stable stage, so one action per pulse
        wr_fall = s.wr_prev && !pins_s.wr_n;
        next_s.wr_prev = pins_s.wr_n;
        next_s.reg_count_m1 = {i_reg_count_strap_hi, i_reg_count_strap_lo};

        if (i_reg.wr) begin
            case (i_reg.addr)
                recorder_port_pkg::ADDR_CONTROL: begin
                    next_s.read_status = i_reg.wdata[recorder_port_pkg::CTRL_READ_STATUS];
                    next_s.mem_target =
                        i_reg.wdata[recorder_port_pkg::CTRL_MEM_MSB:recorder_port_pkg::CTRL_MEM_LSB];
                end
                recorder_port_pkg::ADDR_HOST_DOUT: begin
                    next_s.host_dout = i_reg.wdata[3:0];
                end
                recorder_port_pkg::ADDR_IRQ_STATUS: begin
                    w1c = i_reg.wdata[recorder_port_pkg::EV_W-1:0];
                end
                recorder_port_pkg::ADDR_IRQ_MASK: begin
                    next_s.irq_mask = i_reg.wdata[recorder_port_pkg::EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Nibble taken at the synced falling edge; host keeps it stable
        if (enable && wr_fall) begin
            next_s.host_cmd = i_host_nibble_bus;
            cmd_start = 1'b1;
            ev[recorder_port_pkg::EV_CMD] = 1'b1;
        end

        case (s.st)
            recorder_port_pkg::ST_DOWN: begin
                if (i_sleep_n) begin
                    if (s.rec_cut) begin
                        next_s.st = recorder_port_pkg::ST_POST;
                        next_s.rec_cut = 1'b0;
                    end else if (s.wake_idle || cmd_start) begin
                        next_s.st = recorder_port_pkg::ST_IDLE;
                        next_s.wake_idle = 1'b0;
                    end
                end
            end
            recorder_port_pkg::ST_IDLE: begin
                if (cmd_start) begin
                    case (i_host_nibble_bus)
                        recorder_port_pkg::CMD_REC: next_s.st = recorder_port_pkg::ST_REC;
                        recorder_port_pkg::CMD_VREC: next_s.st = recorder_port_pkg::ST_VWAIT;
                        recorder_port_pkg::CMD_PLAY: next_s.st = recorder_port_pkg::ST_PLAY;
                        default: begin
                        end
                    endcase
                end
            end
            recorder_port_pkg::ST_VWAIT: begin
                if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_STOP) begin
                    next_s.st = recorder_port_pkg::ST_IDLE;
                end else if (i_voice_detect) begin
                    next_s.st = recorder_port_pkg::ST_REC;
                    ev[recorder_port_pkg::EV_VOICE] = 1'b1;
                end
            end
            recorder_port_pkg::ST_REC: begin
                if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_PAUSE) begin
                    next_s.st = recorder_port_pkg::ST_PAUSE;
                    next_s.paused_rec = 1'b1;
                end else if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_STOP) begin
                    next_s.st = recorder_port_pkg::ST_POST;
                end
            end
            recorder_port_pkg::ST_PLAY: begin
                if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_PAUSE) begin
                    next_s.st = recorder_port_pkg::ST_PAUSE;
                    next_s.paused_rec = 1'b0;
                end else if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_STOP) begin
                    next_s.st = recorder_port_pkg::ST_IDLE;
                    ev[recorder_port_pkg::EV_DONE] = 1'b1;
                end
            end
            recorder_port_pkg::ST_PAUSE: begin
                if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_RESUME) begin
                    next_s.st = s.paused_rec ? recorder_port_pkg::ST_REC
                                             : recorder_port_pkg::ST_PLAY;
                end else if (cmd_start && i_host_nibble_bus == recorder_port_pkg::CMD_STOP) begin
                    next_s.st = s.paused_rec ? recorder_port_pkg::ST_POST
                                             : recorder_port_pkg::ST_IDLE;
                    ev[recorder_port_pkg::EV_DONE] = !s.paused_rec;
                end
            end
            recorder_port_pkg::ST_POST: begin
                if (post_done) begin
                    next_s.st = recorder_port_pkg::ST_IDLE;
                    ev[recorder_port_pkg::EV_DONE] = 1'b1;
                end
            end
            default: begin
                next_s.st = recorder_port_pkg::ST_DOWN;
            end
        endcase

        // Sleep keeps every setting; only the sequence stops
        rec_live = (s.st == recorder_port_pkg::ST_REC) || (s.st == recorder_port_pkg::ST_POST) ||
                   (s.st == recorder_port_pkg::ST_PAUSE && s.paused_rec);
        if (!i_sleep_n && s.st != recorder_port_pkg::ST_DOWN) begin
            next_s.st = recorder_port_pkg::ST_DOWN;
            next_s.wake_idle = 1'b1;
            next_s.rec_cut = rec_live;
            ev[recorder_port_pkg::EV_SLEEP] = rec_live;
        end

        post_start = (next_s.st == recorder_port_pkg::ST_POST) &&
                     (s.st != recorder_port_pkg::ST_POST);

        // Busy covers the command window and post-processing
        next_s.busy = cmd_start || (cmd_running && !cmd_done) ||
                      (next_s.st == recorder_port_pkg::ST_POST);
        next_s.rec_play_active = (next_s.st == recorder_port_pkg::ST_REC) ||
                     (next_s.st == recorder_port_pkg::ST_PLAY) ||
                     (next_s.st == recorder_port_pkg::ST_PAUSE);
        next_s.voice_wait_or_pause = (next_s.st == recorder_port_pkg::ST_VWAIT) ||
                     (next_s.st == recorder_port_pkg::ST_PAUSE);

        // Target beyond the strapped count falls back to the last one
        mem_idx = (s.mem_target > s.reg_count_m1) ? s.reg_count_m1 : s.mem_target;
        next_s.mem_sel_n = 4'hf;
        if (next_s.st == recorder_port_pkg::ST_REC || next_s.st == recorder_port_pkg::ST_PLAY ||
            next_s.st == recorder_port_pkg::ST_POST) begin
            next_s.mem_sel_n = ~(recorder_port_pkg::MEM_ONE << mem_idx);
        end

        // Bus released the cycle after the synced read strobe rises
        next_s.nib_oe = enable && !pins_s.rd_n;
        next_s.nib_out = s.read_status ? {1'b0, s.voice_wait_or_pause, s.rec_play_active, s.busy} : s.host_dout;

        next_s.rdata = '0;
        if (i_reg.rd) begin
            case (i_reg.addr)
                recorder_port_pkg::ADDR_STATUS: begin
                    next_s.rdata = {1'b0, s.reg_count_m1, i_host_mode_select,
                                    s.st == recorder_port_pkg::ST_DOWN, s.voice_wait_or_pause, s.rec_play_active,
                                    s.busy};
                end
                recorder_port_pkg::ADDR_CONTROL: begin
                    next_s.rdata = {5'h00, s.mem_target, s.read_status};
                end
                recorder_port_pkg::ADDR_HOST_CMD: next_s.rdata = {4'h0, s.host_cmd};
                recorder_port_pkg::ADDR_HOST_DOUT: next_s.rdata = {4'h0, s.host_dout};
                recorder_port_pkg::ADDR_IRQ_STATUS: next_s.rdata = {4'h0, s.irq_status};
                recorder_port_pkg::ADDR_IRQ_MASK: next_s.rdata = {4'h0, s.irq_mask};
                default: next_s.rdata = '0;
            endcase
        end

        // New event wins over a clear in the same cycle
        next_s.irq_status = (s.irq_status & ~w1c) | ev;

        if (i_chip_reset) begin
            next_s = CORE_INIT;
            next_s.wr_prev = pins_s.wr_n;
            next_s.reg_count_m1 = {i_reg_count_strap_hi, i_reg_count_strap_lo};
            cmd_start = 1'b0;
            post_start = 1'b0;
        end

        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= CORE_INIT;
        end else begin
            s <= next_s;
        end
    end

    assign o_host_nibble_bus = s.nib_out;
    assign o_host_nibble_bus_oe = s.nib_oe;
    assign o_busy = s.busy;
    assign o_rec_play_active = s.rec_play_active;
    assign o_voice_wait_or_pause = s.voice_wait_or_pause;
    assign o_mem_select_1_n = s.mem_sel_n[0];
    assign o_mem_select_2_n = s.mem_sel_n[1];
    assign o_mem_select_3_n = s.mem_sel_n[2];
    assign o_mem_select_4_n = s.mem_sel_n[3];
    assign o_rdata = s.rdata;
    assign o_irq = s.irq;
endmodule

//--- design/recorder_port_pkg.sv
package recorder_port_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CMD_BUSY_NS = 2000;
    localparam int POST_PROC_NS = 50000;
    localparam int CMD_BUSY_CYCLES = (CMD_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POST_PROC_CYCLES = (POST_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 10;
    localparam logic [TIMER_W-1:0] CMD_BUSY_LOAD = TIMER_W'(CMD_BUSY_CYCLES);
    localparam logic [TIMER_W-1:0] POST_PROC_LOAD = TIMER_W'(POST_PROC_CYCLES);

    // Register bus
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_HOST_CMD = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_HOST_DOUT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h5;

    // Control register fields
    localparam int CTRL_READ_STATUS = 0;
    localparam int CTRL_MEM_LSB = 1;
    localparam int CTRL_MEM_MSB = 2;

    // Interrupt event bits
    localparam int EV_W = 4;
    localparam int EV_CMD = 0;
    localparam int EV_VOICE = 1;
    localparam int EV_DONE = 2;
    localparam int EV_SLEEP = 3;

    // Host command nibbles
    localparam logic [3:0] CMD_REC = 4'h1;
    localparam logic [3:0] CMD_PLAY = 4'h2;
    localparam logic [3:0] CMD_VREC = 4'h3;
    localparam logic [3:0] CMD_PAUSE = 4'h4;
    localparam logic [3:0] CMD_STOP = 4'h5;
    localparam logic [3:0] CMD_RESUME = 4'h6;

    localparam logic [3:0] MEM_ONE = 4'h1;

    typedef enum logic [6:0] {
        ST_DOWN = 7'h01,
        ST_IDLE = 7'h02,
        ST_REC = 7'h04,
        ST_PLAY = 7'h08,
        ST_VWAIT = 7'h10,
        ST_PAUSE = 7'h20,
        ST_POST = 7'h40
    } ctrl_state_type;

    typedef struct packed {
        logic ce_n;
        logic ce;
        logic wr_n;
        logic rd_n;
    } host_strobes_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

//--- design/strobe_sync.sv
`timescale 1ns/1ps
module strobe_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_type;

    sync_type s;
    sync_type next_s;

    always_comb begin
        next_s.meta = i_async;
        next_s.stable = s.meta;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= {IDLE, IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.stable;
endmodule

//--- design/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Control
    input wire logic i_clear,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_load,
    // Status
    output logic o_running,
    output logic o_done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_type;

    timer_type s;
    timer_type next_s;

    always_comb begin
        next_s = s;
        if (i_clear) begin
            next_s.count = '0;
        end else if (i_start) begin
            next_s.count = i_load;
        end else if (s.count != '0) begin
            next_s.count = s.count - WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_running = (s.count != '0);
    assign o_done = (s.count == WIDTH'(1)) && !i_clear && !i_start;
endmodule

//--- sim/recorder_mcu_control_port_assertions.sv
`timescale 1ns/1ps
module recorder_mcu_control_port_assertions (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Inputs seen
    input wire logic i_chip_reset,
    input wire logic i_sleep_n,
    input wire recorder_port_pkg::host_strobes_type i_host_strobes,
    input wire recorder_port_pkg::reg_req_type i_reg,
    // Outputs seen
    input wire logic o_host_nibble_bus_oe,
    input wire logic o_busy,
    input wire logic o_rec_play_active,
    input wire logic o_voice_wait_or_pause,
    input wire logic o_mem_select_1_n,
    input wire logic o_mem_select_2_n,
    input wire logic o_mem_select_3_n,
    input wire logic o_mem_select_4_n,
    input wire logic [recorder_port_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    localparam int BUSY_LEN = recorder_port_pkg::CMD_BUSY_CYCLES;
    localparam int POST_LEN = recorder_port_pkg::POST_PROC_CYCLES;
    logic [3:0] sel;
    logic [9:0] busy_len;
    logic en;
    assign sel = ~{o_mem_select_4_n, o_mem_select_3_n, o_mem_select_2_n, o_mem_select_1_n};
    assign en = !i_host_strobes.ce_n || i_host_strobes.ce;
    // Counts busy length; helper only, no design state copied
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_len <= '0;
        end else begin
            busy_len <= o_busy ? busy_len + 10'h001 : 10'h000;
        end
    end
    chk_drive_on_read: assert property (o_host_nibble_bus_oe |-> !$past(i_host_strobes.rd_n, 3))
        else $error("bus driven without a read");
    chk_read_enabled: assert property ($rose(o_host_nibble_bus_oe) |-> $past(en, 3))
        else $error("read taken while disabled");
    chk_write_taken: assert property ($rose(o_busy) && o_rec_play_active |->
        !$past(i_host_strobes.wr_n, 2) && $past(en, 2))
        else $error("command started without write");
    chk_busy_length: assert property ($fell(o_busy) && !$past(i_chip_reset) |->
        busy_len == BUSY_LEN || busy_len == POST_LEN || busy_len == POST_LEN + 1)
        else $error("busy length wrong");
    chk_one_select: assert property ($onehot0(sel))
        else $error("several memory selects low");
    chk_active_select: assert property (o_rec_play_active && !o_voice_wait_or_pause |-> $onehot(sel))
        else $error("no memory selected while active");
    chk_chip_reset: assert property (i_chip_reset |=> !o_busy && !o_rec_play_active &&
        !o_voice_wait_or_pause && !o_host_nibble_bus_oe && !o_irq && sel == 4'h0)
        else $error("chip reset left state");
    chk_sleep_halts: assert property (!i_sleep_n [*3] |->
        !o_rec_play_active && !o_voice_wait_or_pause && sel == 4'h0)
        else $error("active while asleep");
    chk_rdata_idle: assert property (!$past(i_reg.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    cover property ($rose(o_busy));
    cover property ($rose(o_host_nibble_bus_oe));
    cover property ($rose(o_voice_wait_or_pause));
endmodule

bind recorder_mcu_control_port recorder_mcu_control_port_assertions chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_chip_reset(i_chip_reset), .i_sleep_n(i_sleep_n),
    .i_host_strobes(i_host_strobes), .i_reg(i_reg), .o_host_nibble_bus_oe(o_host_nibble_bus_oe),
    .o_busy(o_busy), .o_rec_play_active(o_rec_play_active),
    .o_voice_wait_or_pause(o_voice_wait_or_pause), .o_mem_select_1_n(o_mem_select_1_n),
    .o_mem_select_2_n(o_mem_select_2_n), .o_mem_select_3_n(o_mem_select_3_n),
    .o_mem_select_4_n(o_mem_select_4_n), .o_rdata(o_rdata), .o_irq(o_irq));

//--- sim/host_mcu_model.sv
`timescale 1ns/1ps
module host_mcu_model (
    // Clock
    input wire logic i_clk,
    // Device side
    input wire logic [3:0] i_dev_nibble,
    input wire logic i_dev_oe,
    input wire logic i_busy,
    output recorder_port_pkg::host_strobes_type o_strobes,
    output logic [3:0] o_bus
);
    logic drive;
    logic saw;
    logic [3:0] data;
    logic [3:0] last;
    // Floating bus shows the inverse, so stale data never passes
    assign o_bus = i_dev_oe ? i_dev_nibble : (drive ? data : ~last);
    always @(posedge i_clk) begin
        if (i_dev_oe || drive) begin
            last <= o_bus;
        end
        if (i_dev_oe) begin
            saw <= 1'b1;
        end
    end
    initial begin
        o_strobes = 4'hb;
        drive = 1'b0;
        data = 4'h0;
        last = 4'h0;
        saw = 1'b0;
    end
    task automatic host_write(input logic [3:0] nib, input logic [1:0] en);
        int n;
        n = 0;
        @(posedge i_clk);
        while (i_busy !== 1'b0 && n < 1000) begin
            @(posedge i_clk);
            n++;
        end
        o_strobes <= {en, 2'b01};
        data <= nib;
        drive <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_strobes.wr_n <= 1'b1;
        @(posedge i_clk);
        drive <= 1'b0;
        o_strobes <= 4'hb;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic host_read(input logic [1:0] en, output logic [3:0] nib, output logic seen);
        @(posedge i_clk);
        saw <= 1'b0;
        o_strobes <= {en, 2'b10};
        repeat (5) @(posedge i_clk);
        nib = o_bus;
        o_strobes <= 4'hb;
        repeat (4) @(posedge i_clk);
        seen = saw;
    endtask
endmodule

//--- sim/tb_recorder_mcu_control_port.sv
`timescale 1ns/1ps
module tb_recorder_mcu_control_port;
    localparam logic [1:0] EN_LOW = 2'b00;
    localparam logic [1:0] EN_HIGH = 2'b11;
    localparam logic [1:0] EN_OFF = 2'b10;
    logic i_clk, i_reset_n, chip_rst, sleep_n, mode, s_lo, s_hi, voice, saw;
    logic busy, rec_play_active, voice_wait_or_pause, oe, irq, sel1_n, sel2_n, sel3_n, sel4_n;
    logic [3:0] bus, nib_out, nib;
    logic [7:0] rdata;
    recorder_port_pkg::host_strobes_type strobes;
    recorder_port_pkg::reg_req_type req;
    int failures, comparisons;
    recorder_mcu_control_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_chip_reset(chip_rst),
        .i_sleep_n(sleep_n), .i_host_mode_select(mode), .i_reg_count_strap_lo(s_lo),
        .i_reg_count_strap_hi(s_hi), .i_voice_detect(voice), .i_host_strobes(strobes),
        .i_host_nibble_bus(bus), .o_host_nibble_bus(nib_out), .o_host_nibble_bus_oe(oe),
        .o_busy(busy), .o_rec_play_active(rec_play_active), .o_voice_wait_or_pause(voice_wait_or_pause),
        .o_mem_select_1_n(sel1_n), .o_mem_select_2_n(sel2_n), .o_mem_select_3_n(sel3_n),
        .o_mem_select_4_n(sel4_n), .i_reg(req), .o_rdata(rdata), .o_irq(irq));
    host_mcu_model mcu (.i_clk(i_clk), .i_dev_nibble(nib_out), .i_dev_oe(oe), .i_busy(busy),
        .o_strobes(strobes), .o_bus(bus));
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        req.rd <= 1'b0;
        @(negedge i_clk);
        check(rdata, exp, what);
    endtask
    task automatic pins(input logic [3:0] exp, input string what);
        @(negedge i_clk);
        check({4'h0, busy, rec_play_active, voice_wait_or_pause, irq}, {4'h0, exp}, what);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        check({7'h0, busy}, 8'h00, "busy stuck");
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        #2000000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        failures = 0;
        comparisons = 0;
        {i_reset_n, chip_rst, voice, s_hi} = 4'h0;
        {sleep_n, mode, s_lo} = 3'h7;
        req = '0;
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h38, "reset status");
        for (int i = 0; i < 4; i++) begin
            s_lo <= i[0];
            s_hi <= i[1];
            repeat (3) @(posedge i_clk);
            rd_chk(recorder_port_pkg::ADDR_STATUS, {1'b0, i[1:0], 5'h18}, "strap count");
        end
        {s_hi, s_lo} <= 2'b01;
        mode <= 1'b0;
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h28, "mode low");
        mode <= 1'b1;
        $display("test reset and straps done");
        mcu.host_write(recorder_port_pkg::CMD_STOP, EN_LOW);
        wait_idle();
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h30, "woken");
        mode <= 1'b0;
        mcu.host_write(recorder_port_pkg::CMD_REC, EN_LOW);
        pins(4'h0, "stand-alone write");
        mode <= 1'b1;
        mcu.host_write(recorder_port_pkg::CMD_REC, EN_OFF);
        pins(4'h0, "disabled write");
        mcu.host_read(EN_OFF, nib, saw);
        check({7'h0, saw}, 8'h00, "disabled read drove bus");
        rd_chk(recorder_port_pkg::ADDR_HOST_CMD, 8'h05, "refused not latched");
        $display("test refusals done");
        reg_wr(recorder_port_pkg::ADDR_IRQ_MASK, 8'h01);
        mcu.host_write(recorder_port_pkg::CMD_REC, EN_HIGH);
        pins(4'hd, "record start");
        check({7'h0, sel1_n}, 8'h00, "memory one selected");
        reg_wr(recorder_port_pkg::ADDR_CONTROL, 8'h06);
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h33, "busy in status");
        check({6'h0, sel2_n, sel1_n}, 8'h01, "target clamped");
        rd_chk(recorder_port_pkg::ADDR_HOST_CMD, 8'h01, "nibble latched");
        rd_chk(3'h7, 8'h00, "unmapped");
        reg_wr(recorder_port_pkg::ADDR_IRQ_STATUS, 8'h01);
        pins(4'hc, "irq cleared");
        reg_wr(recorder_port_pkg::ADDR_IRQ_MASK, 8'h00);
        wait_idle();
        reg_wr(recorder_port_pkg::ADDR_CONTROL, 8'h01);
        mcu.host_read(EN_LOW, nib, saw);
        check({4'h0, nib}, 8'h02, "host status read");
        reg_wr(recorder_port_pkg::ADDR_CONTROL, 8'h00);
        reg_wr(recorder_port_pkg::ADDR_HOST_DOUT, 8'h0a);
        mcu.host_read(EN_HIGH, nib, saw);
        check({4'h0, nib}, 8'h0a, "host data read");
        $display("test record and host read done");
        mcu.host_write(recorder_port_pkg::CMD_PAUSE, EN_LOW);
        wait_idle();
        pins(4'h6, "paused");
        mcu.host_write(recorder_port_pkg::CMD_RESUME, EN_LOW);
        wait_idle();
        pins(4'h4, "resumed");
        reg_wr(recorder_port_pkg::ADDR_CONTROL, 8'h01);
        sleep_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        pins(4'h0, "sleep halts");
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h38, "asleep status");
        repeat (20) @(posedge i_clk);
        sleep_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        pins(4'h8, "post-processing");
        wait_idle();
        pins(4'h0, "idle after post");
        rd_chk(recorder_port_pkg::ADDR_CONTROL, 8'h01, "control kept");
        reg_wr(recorder_port_pkg::ADDR_IRQ_MASK, 8'h08);
        pins(4'h1, "sleep cut irq");
        reg_wr(recorder_port_pkg::ADDR_IRQ_MASK, 8'h00);
        pins(4'h0, "irq masked");
        $display("test pause and sleep done");
        mcu.host_write(recorder_port_pkg::CMD_VREC, EN_LOW);
        wait_idle();
        pins(4'h2, "voice wait");
        voice <= 1'b1;
        repeat (3) @(posedge i_clk);
        pins(4'h4, "voice found");
        voice <= 1'b0;
        chip_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        chip_rst <= 1'b0;
        pins(4'h0, "chip reset pins");
        rd_chk(recorder_port_pkg::ADDR_STATUS, 8'h38, "chip reset status");
        rd_chk(recorder_port_pkg::ADDR_CONTROL, 8'h00, "chip reset control");
        $display("test voice and chip reset done");
        test_done();
    end
endmodule
